// File: hw/gxp_defs.svh
`ifndef GXP_DEFS_SVH
`define GXP_DEFS_SVH

`define GXP_LINES        8
`define GXP_ADDR_W       7
`define GXP_BASE_ADDR    7'h20
`define GXP_FRAME_BITS   4'h8
`define GXP_LAST_BIT     4'h7
`define GXP_RW_BIT       0
`define GXP_DIR_RST      8'hFF
`define GXP_OUT_RST      8'hFF
`define GXP_POL_RST      8'h00
`define GXP_LATCH_RST    8'h00
`define GXP_MASK_RST     8'hFF
`define GXP_PULL_EN_RST  8'h00
`define GXP_PULL_UP_RST  8'hFF
`define GXP_DRIVE_RST    16'hFFFF
`define GXP_OD_RST       1'b0

`endif

// File: hw/gxp_pkg.sv
package gxp_pkg;

  typedef logic [7:0]  gxp_line_t;
  typedef logic [15:0] gxp_drive_t;

  // configuration written by the local control port
  typedef struct packed {
    gxp_line_t  dir;       // 1 = input
    gxp_line_t  out;
    gxp_line_t  pol;       // 1 = inverted report
    gxp_line_t  latch_en;
    gxp_line_t  mask;      // 1 = masked
    gxp_line_t  pull_en;
    gxp_line_t  pull_up;   // 1 = pull-up, 0 = pull-down
    gxp_drive_t drive;     // two bits per line
    logic       od;        // 1 = open-drain bank
  } gxp_cfg_s;

  // per-line pad controls
  typedef struct packed {
    gxp_line_t  out;
    gxp_line_t  oe;
    gxp_line_t  pull_en;
    gxp_line_t  pull_up;
    gxp_drive_t drive;
  } gxp_pad_s;

endpackage

// File: hw/gxp_core.sv
`include "gxp_defs.svh"

module gxp_core #(
  parameter logic [6:0] BASE_ADDR = `GXP_BASE_ADDR  // arbitrary value
) (
  // system
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // local configuration port
  input  wire logic             i_cfg_wr,
  input  wire gxp_pkg::gxp_cfg_s i_cfg,
  output logic                  o_cfg_busy,
  output gxp_pkg::gxp_cfg_s     o_cfg,
  // address strap pin
  input  wire logic             i_addr_sel,
  // serial link, link clock domain
  input  wire logic             i_lnk_clk,
  input  wire logic             i_lnk_frame,
  input  wire logic             i_lnk_data,
  // link results
  output logic                  o_rd_hit,
  output logic                  o_wr_hit,
  output logic [6:0]            o_own_addr,
  // port lines
  input  wire logic [7:0]       i_gpio_in,
  output gxp_pkg::gxp_pad_s     o_pad,
  // input register and interrupt
  output logic [7:0]            o_in_data,
  output logic [7:0]            o_int_status,
  output logic                  o_int_o,
  output logic                  o_int_oe
);

  import gxp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  gxp_cfg_s   cfg_reg;
  gxp_pad_s   pad_reg;
  gxp_pad_s   pad_next;

  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic [7:0] in_reg;
  logic [7:0] in_next;
  logic [7:0] latched_reg;
  logic [7:0] latched_next;
  logic [7:0] snap_reg;
  logic [7:0] snap_next;
  logic [7:0] int_reg;
  logic [7:0] int_next;
  logic [7:0] in_data_reg;
  logic       int_oe_reg;

  logic       sel_s1_reg;
  logic       sel_s2_reg;
  logic       strap_done_reg;
  logic [1:0] settle_reg;
  logic [6:0] own_addr_reg;

  logic       lnk_rst_n;
  logic [3:0] lnk_cnt_reg;
  logic [7:0] lnk_sh_reg;
  logic [7:0] lnk_hold_reg;
  logic       lnk_tgl_reg;

  logic       tgl_s1_reg;
  logic       tgl_s2_reg;
  logic       tgl_s3_reg;
  logic       evt_reg;
  logic [7:0] byte_reg;
  logic       rd_hit_reg;
  logic       wr_hit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // decode wires

  wire        byte_evt  = tgl_s2_reg ^ tgl_s3_reg;
  wire        addr_hit  = strap_done_reg
                          && (byte_reg[7:1] == own_addr_reg);
  wire        rw_bit    = byte_reg[`GXP_RW_BIT];
  wire        rd_hit    = evt_reg && addr_hit && rw_bit;
  wire        wr_hit    = evt_reg && addr_hit && !rw_bit;
  wire        lnk_last  = (lnk_cnt_reg == `GXP_LAST_BIT);
  wire        lnk_full  = (lnk_cnt_reg == `GXP_FRAME_BITS);
  wire [7:0]  lnk_byte  = {lnk_sh_reg[6:0], i_lnk_data};
  wire [6:0]  strap_adr = {BASE_ADDR[6:1], sel_s2_reg};

  // the frame level ends the link-side count without any link clock edge
  assign lnk_rst_n = i_arst_n & i_lnk_frame;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_reg <= '{
        dir:      `GXP_DIR_RST,
        out:      `GXP_OUT_RST,
        pol:      `GXP_POL_RST,
        latch_en: `GXP_LATCH_RST,
        mask:     `GXP_MASK_RST,
        pull_en:  `GXP_PULL_EN_RST,
        pull_up:  `GXP_PULL_UP_RST,
        drive:    `GXP_DRIVE_RST,
        od:       `GXP_OD_RST
      };
    end else if (i_cfg_wr) begin
      cfg_reg <= i_cfg;
    end
  end

  assign o_cfg      = cfg_reg;
  assign o_cfg_busy = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // per-line pad and input logic

  genvar g;
  generate
    for (g = 0; g < `GXP_LINES; g++) begin : g_line
      wire pin     = pin_s2_reg[g];
      wire is_out  = !cfg_reg.dir[g];
      wire drv_hi  = cfg_reg.out[g];
      wire changed = (pin != in_reg[g]);

      // output stage
      assign pad_next.out[g]     = drv_hi;
      assign pad_next.oe[g]      = is_out
                                   && !(cfg_reg.od && drv_hi);
      assign pad_next.pull_en[g] = cfg_reg.pull_en[g];
      assign pad_next.pull_up[g] = cfg_reg.pull_up[g];
      assign pad_next.drive[2*g +: 2] = cfg_reg.drive[2*g +: 2];

      // input register: tracks the pin, or holds a latched change
      assign in_next[g] = (cfg_reg.latch_en[g] && latched_reg[g]
                           && !rd_hit) ? in_reg[g] : pin;

      // a new capture wins over the clearing read
      assign latched_next[g] = cfg_reg.latch_en[g]
                               && ((latched_reg[g] && !rd_hit)
                                   || changed);

      // state last seen by the controller
      assign snap_next[g] = rd_hit ? in_reg[g] : snap_reg[g];

      // pending while unmasked and differing from what was read
      assign int_next[g] = !cfg_reg.mask[g]
                           && (in_next[g] != snap_next[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= i_gpio_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input, interrupt and pad registers

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      in_reg      <= 8'h00;
      latched_reg <= 8'h00;
      snap_reg    <= 8'h00;
      int_reg     <= 8'h00;
      in_data_reg <= 8'h00;
      int_oe_reg  <= 1'b0;
      pad_reg     <= '{
        out:     `GXP_OUT_RST,
        oe:      8'h00,
        pull_en: `GXP_PULL_EN_RST,
        pull_up: `GXP_PULL_UP_RST,
        drive:   `GXP_DRIVE_RST
      };
    end else begin
      in_reg      <= in_next;
      latched_reg <= latched_next;
      snap_reg    <= snap_next;
      int_reg     <= int_next;
      in_data_reg <= in_next ^ cfg_reg.pol;
      int_oe_reg  <= |int_next;
      pad_reg     <= pad_next;
    end
  end

  assign o_pad        = pad_reg;
  assign o_in_data    = in_data_reg;
  assign o_int_status = int_reg;
  assign o_int_o      = 1'b0;
  assign o_int_oe     = int_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // address strap, caught after reset release

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_s1_reg     <= 1'b0;
      sel_s2_reg     <= 1'b0;
      strap_done_reg <= 1'b0;
      settle_reg     <= 2'h0;
      own_addr_reg   <= 7'h00;
    end else begin
      sel_s1_reg     <= i_addr_sel;
      sel_s2_reg     <= sel_s1_reg;
      // keep loading until the strap has crossed both sync stages
      settle_reg     <= {settle_reg[0], 1'b1};
      strap_done_reg <= settle_reg[1];
      if (!strap_done_reg) begin
        own_addr_reg <= strap_adr;
      end
    end
  end

  assign o_own_addr = own_addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: shift one address byte per frame

  always_ff @(posedge i_lnk_clk or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      lnk_cnt_reg <= 4'h0;
      lnk_sh_reg  <= 8'h00;
    end else if (!lnk_full) begin
      lnk_cnt_reg <= lnk_cnt_reg + 4'h1;
      lnk_sh_reg  <= lnk_byte;
    end
  end

  // hand-over word and toggle survive the end of the frame
  always_ff @(posedge i_lnk_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lnk_hold_reg <= 8'h00;
      lnk_tgl_reg  <= 1'b0;
    end else if (i_lnk_frame && lnk_last) begin
      lnk_hold_reg <= lnk_byte;
      lnk_tgl_reg  <= !lnk_tgl_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle crossing into the system domain

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      evt_reg    <= 1'b0;
      byte_reg   <= 8'h00;
    end else begin
      tgl_s1_reg <= lnk_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      evt_reg    <= byte_evt;
      if (byte_evt) begin
        byte_reg <= lnk_hold_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address match results

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_hit_reg <= 1'b0;
      wr_hit_reg <= 1'b0;
    end else begin
      rd_hit_reg <= rd_hit;
      wr_hit_reg <= wr_hit;
    end
  end

  assign o_rd_hit = rd_hit_reg;
  assign o_wr_hit = wr_hit_reg;

endmodule // gxp_core

// File: test/gxp_checker.sv
module gxp_checker
  import gxp_pkg::*;
#(
  parameter logic [6:0] BASE_ADDR = 7'h20
) (
  // system
  input wire logic       i_clk,
  input wire logic       i_arst_n,
  // configuration
  input wire logic       i_cfg_wr,
  input wire gxp_cfg_s   i_cfg,
  input wire gxp_cfg_s   o_cfg,
  // link, pads, interrupt
  input wire logic       o_rd_hit,
  input wire logic       o_wr_hit,
  input wire logic [6:0] o_own_addr,
  input wire gxp_pad_s   o_pad,
  input wire logic [7:0] o_int_status,
  input wire logic       o_int_o,
  input wire logic       o_int_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_cfg_wr;
    i_cfg_wr ##1 1'b1;
  endsequence

  cfg_load_a: assert property (
    i_cfg_wr |=> o_cfg == $past(i_cfg)) else $error("cfg readback");
  pad_out_a: assert property (
    s_cfg_wr |=> o_pad.out == $past(i_cfg.out, 2)) else $error("pad out");
  pad_oe_a: assert property (
    o_pad.oe == (~$past(o_cfg.dir) & ~({8{$past(o_cfg.od)}}
    & $past(o_cfg.out)))) else $error("pad enable");
  pad_misc_a: assert property (
    {o_pad.pull_en, o_pad.pull_up, o_pad.drive} ==
    $past({o_cfg.pull_en, o_cfg.pull_up, o_cfg.drive})) else $error("pad");
  int_any_a: assert property (
    o_int_oe == |o_int_status) else $error("int vs status");
  int_od_a: assert property (
    !o_int_o) else $error("int data driven high");
  mask_stop_a: assert property (
    $stable(o_cfg.mask) |-> (o_int_status & o_cfg.mask) == 8'h00)
    else $error("masked status");
  own_addr_a: assert property (
    $past(i_arst_n) |-> o_own_addr[6:1] == BASE_ADDR[6:1])
    else $error("own address");
  hit_pulse_a: assert property (
    (o_rd_hit || o_wr_hit) |-> !(o_rd_hit && o_wr_hit)
    ##1 !(o_rd_hit || o_wr_hit)) else $error("hit pulse");
endmodule  // gxp_checker

// File: test/gxp_link_host.sv
module gxp_link_host (
  // link toward the expander
  output logic o_clk,
  output logic o_frame,
  output logic o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_clk = 1'b0;
    o_frame = 1'b0;
    o_data = 1'b0;
  end
  task automatic send(input logic [7:0] b, input int half);
    o_frame = 1'b1;
    for (int k = 7; k >= 0; k--) begin
      o_data = b[k];
      #half o_clk = 1'b1;
      #half o_clk = 1'b0;
    end
    #half o_frame = 1'b0;
    o_data = ~o_data;  // released line shows no stale bit
  endtask
endmodule  // gxp_link_host

// File: test/tb.sv
`include "gxp_defs.svh"
module tb;
  import gxp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] BASE = 7'h2A;
  logic i_clk = 0, i_arst_n = 0, i_cfg_wr = 0, i_addr_sel = 1;
  logic i_lnk_clk, i_lnk_frame, i_lnk_data;
  logic o_cfg_busy, o_rd_hit, o_wr_hit, o_int_o, o_int_oe;
  logic [7:0] i_gpio_in = 8'h00, o_in_data, o_int_status;
  logic [6:0] o_own_addr;
  gxp_cfg_s i_cfg = '0, o_cfg, c;
  gxp_pad_s o_pad;
  int miscompares = 0, n_compared = 0, n_rd = 0, n_wr = 0;
  gxp_cfg_s rst_cfg = {`GXP_DIR_RST, `GXP_OUT_RST, `GXP_POL_RST,
    `GXP_LATCH_RST, `GXP_MASK_RST, `GXP_PULL_EN_RST, `GXP_PULL_UP_RST,
    `GXP_DRIVE_RST, `GXP_OD_RST};

  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_rd_hit === 1'b1) n_rd++;
    if (o_wr_hit === 1'b1) n_wr++;
  end

  gxp_link_host i_host (.o_clk(i_lnk_clk), .o_frame(i_lnk_frame),
    .o_data(i_lnk_data));
  gxp_core #(.BASE_ADDR(BASE)) i_dut (.i_clk, .i_arst_n, .i_cfg_wr,
    .i_cfg, .o_cfg_busy, .o_cfg, .i_addr_sel, .i_lnk_clk, .i_lnk_frame,
    .i_lnk_data, .o_rd_hit, .o_wr_hit, .o_own_addr, .i_gpio_in, .o_pad,
    .o_in_data, .o_int_status, .o_int_o, .o_int_oe);

  task automatic chk(input string n, input logic [128:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic put_cfg(input gxp_cfg_s v);
    @(posedge i_clk);
    i_cfg <= v;
    i_cfg_wr <= 1'b1;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge i_clk);
    i_gpio_in <= v;
    cyc(5);
  endtask
  task automatic xfer(input logic [7:0] b);
    i_host.send(b, 3);
    cyc(10);
  endtask
  task automatic do_reset(input logic s);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    i_addr_sel <= s;
    cyc(16);
    i_arst_n <= 1'b1;
    cyc(4);
  endtask
  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b1);
    chk("cfg", rst_cfg, o_cfg);
    chk("oe", 8'h00, o_pad.oe);
    chk("busy", 1'b0, o_cfg_busy);
    chk("addr", {BASE[6:1], 1'b1}, o_own_addr);
    pins(8'h01);
    chk("in", 8'h01, o_in_data);
    chk("int", 1'b0, o_int_oe);
    c = {8'hF0, 8'hA5, 8'h02, 8'h04, 8'h00, 8'h3C, 8'h0F, 16'h1BE4, 1'b0};
    put_cfg(c);
    chk("cfg", c, o_cfg);
    chk("pad", {8'hA5, 8'h0F, 8'h3C, 8'h0F, 16'h1BE4}, o_pad);
    chk("in", 8'h03, o_in_data);
    chk("sts", 8'h01, o_int_status);
    chk("int", 1'b1, o_int_oe);
    xfer({BASE[6:1], 1'b1, 1'b1});
    chk("rd", 1, n_rd);
    chk("sts", 8'h00, o_int_status);
    chk("int", 1'b0, o_int_oe);
    pins(8'h11);
    chk("sts", 8'h10, o_int_status);
    pins(8'h01);
    chk("sts", 8'h00, o_int_status);
    pins(8'h05);
    pins(8'h01);
    chk("in", 8'h07, o_in_data);
    chk("int", 1'b1, o_int_oe);
    xfer({BASE[6:1], 1'b1, 1'b1});
    chk("in", 8'h03, o_in_data);
    xfer({BASE[6:1], 1'b1, 1'b0});
    xfer({BASE[6:1], 1'b0, 1'b1});
    chk("wr", 1, n_wr);
    chk("rd", 2, n_rd);
    c.od = 1'b1;
    put_cfg(c);
    chk("oe", 8'h0A, o_pad.oe);
    do_reset(1'b0);
    chk("cfg", rst_cfg, o_cfg);
    chk("addr", {BASE[6:1], 1'b0}, o_own_addr);
    xfer({BASE[6:1], 1'b0, 1'b0});
    chk("wr", 2, n_wr);
    close_out;
  end

  initial begin
    cyc(4000);
    miscompares++;
    close_out;
  end
endmodule  // tb

bind gxp_core gxp_checker #(.BASE_ADDR(BASE_ADDR)) i_chk (.i_clk,
  .i_arst_n, .i_cfg_wr, .i_cfg, .o_cfg, .o_rd_hit, .o_wr_hit, .o_own_addr,
  .o_pad, .o_int_status, .o_int_o, .o_int_oe);
